// >>> supply_monitor_consts.vh
/*
  Offsets, field positions and reset values of the supply voltage monitor.
  Assumes inclusion by bare name from the design file.
*/
`ifndef SUPPLY_MONITOR_CONSTS_VH
`define SUPPLY_MONITOR_CONSTS_VH

`define SM_ADDR_W             12
`define SM_OFF_FLAGS_LEVELS   12'h0fc6
`define SM_OFF_ENABLE_MODE    12'h0fc7
`define SM_RESET_FLAGS_LEVELS 8'h00
`define SM_RESET_ENABLE_MODE  8'h00

`define SM_LVL1_LO            0
`define SM_LIVE1_BIT          2
`define SM_STICKY1_BIT        3
`define SM_LVL2_LO            4
`define SM_LIVE2_BIT          6
`define SM_STICKY2_BIT        7

`define SM_EN1_BIT            0
`define SM_MOD1_BIT           1
`define SM_EN2_BIT            2
`define SM_MOD2_BIT           3
`define SM_WAKE_LO            4

`define SM_WAKE_PIN           2'b00
`define SM_WAKE_SUPPLY        2'b01
`define SM_WAKE_EITHER        2'b10

`endif

// >>> supply_monitor_ctrl.v
/*
  Control logic of a two-channel supply voltage monitor: register file,
  comparator synchronisers, sticky and live flags, request outputs, wake select.
  Assumes comparator outputs asynchronous; reset_i is power-on or external only.
*/
// Design decision made here: strobed register access.
`default_nettype none
`include "supply_monitor_consts.vh"

// What this block does
// RULE1 - Enabled channel below level raises interrupt or reset
// RULE2 - Channel one mode bit picks interrupt/reset
// RULE3 - Channel two mode bit picks interrupt/reset
// RULE4 - Channel one enable bit gates its detection
// RULE5 - Channel two enable bit gates its detection
// RULE6 - Channel one sticky flag holds after recovery
// RULE7 - Channel two sticky flag holds after recovery
// RULE8 - Channel one live flag shows comparison
// RULE9 - Channel two live flag shows comparison
// RULE10 - Channel one level field drives comparator select
// RULE11 - Channel two level field drives comparator select
// RULE12 - Hardware set beats software clear
// RULE13 - Software may only clear sticky flags
// RULE14 - First register cleared only by reset
// RULE15 - Second register cleared only by reset
// RULE16 - Top two bits of second register read zero
// RULE17 - Wake field picks stop-mode release source
// RULE18 - Wake codes: pin, supply, either
// RULE19 - Flags update only while channel enabled
// RULE20 - Low-power events act after return to run; reset requests are not gated by run mode and act at once
// RULE21 - Enabling while already low requests at once
// RULE22 - Comparator outputs pass two-flop synchroniser
// RULE23 - Reset request holds while supply stays low
module supply_monitor_ctrl (
  // Clock and reset
  input  wire        mclk_i,
  input  wire        reset_i,
  // Register port
  input  wire [11:0] addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [7:0]  rdata_o,
  // Analog comparators, high while supply is below level
  input  wire        below_one_i,
  input  wire        below_two_i,
  output wire [1:0]  threshold_select_one_o,
  output wire [1:0]  threshold_select_two_o,
  // Operating state and stop pin
  input  wire        run_mode_i,
  input  wire        stop_pin_i,
  // Requests
  output wire        irq_one_o,
  output wire        irq_two_o,
  output wire        rst_req_one_o,
  output wire        rst_req_two_o,
  output wire        wake_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [1:0] sync1_ff;
  reg  [1:0] sync2_ff;
  reg  [1:0] lvl_one_ff;
  reg  [1:0] lvl_two_ff;
  reg        sticky_one_ff;
  reg        sticky_two_ff;
  reg        live_one_ff;
  reg        live_two_ff;
  reg        channel_on_one_ff;
  reg        channel_on_two_ff;
  reg        event_kind_one_ff;
  reg        event_kind_two_ff;
  reg  [1:0] wake_source_select_ff;

  wire       low_one;
  wire       low_two;
  wire       act_one;
  wire       act_two;
  wire       wr_fl;
  wire       wr_em;
  wire       nxt_sticky_one;
  wire       nxt_sticky_two;
  wire       nxt_live_one;
  wire       nxt_live_two;
  wire [7:0] nxt_rdata;
  reg        wake_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchronisers
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_ff <= 2'b00;
      sync2_ff <= 2'b00;
    end else begin
      sync1_ff <= {sync1_ff[0], below_one_i}; // RULE22
      sync2_ff <= {sync2_ff[0], below_two_i}; // RULE22
    end
  end

  assign low_one = sync1_ff[1];
  assign low_two = sync2_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // Flag updates
  assign act_one = channel_on_one_ff & run_mode_i; // RULE4 RULE19 RULE20
  assign act_two = channel_on_two_ff & run_mode_i; // RULE5 RULE19 RULE20
  assign wr_fl   = wr_i & (addr_i == `SM_OFF_FLAGS_LEVELS);
  assign wr_em   = wr_i & (addr_i == `SM_OFF_ENABLE_MODE);

  assign nxt_sticky_one = (act_one & low_one) ? 1'b1 : // RULE6 RULE12
                          (wr_fl & ~wdata_i[`SM_STICKY1_BIT]) ? 1'b0 : // RULE13
                          sticky_one_ff;
  assign nxt_sticky_two = (act_two & low_two) ? 1'b1 : // RULE7 RULE12
                          (wr_fl & ~wdata_i[`SM_STICKY2_BIT]) ? 1'b0 : // RULE13
                          sticky_two_ff;
  assign nxt_live_one   = act_one ? low_one : live_one_ff; // RULE8 RULE19
  assign nxt_live_two   = act_two ? low_two : live_two_ff; // RULE9 RULE19

  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin // RULE14
      lvl_one_ff    <= 2'b00;
      lvl_two_ff    <= 2'b00;
      sticky_one_ff <= 1'b0;
      sticky_two_ff <= 1'b0;
      live_one_ff   <= 1'b0;
      live_two_ff   <= 1'b0;
    end else begin
      sticky_one_ff <= nxt_sticky_one;
      sticky_two_ff <= nxt_sticky_two;
      live_one_ff   <= nxt_live_one;
      live_two_ff   <= nxt_live_two;
      if (wr_fl) begin
        lvl_one_ff <= wdata_i[`SM_LVL1_LO+1:`SM_LVL1_LO]; // RULE10
        lvl_two_ff <= wdata_i[`SM_LVL2_LO+1:`SM_LVL2_LO]; // RULE11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable and mode register
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin // RULE15
      channel_on_one_ff     <= 1'b0;
      event_kind_one_ff     <= 1'b0;
      channel_on_two_ff     <= 1'b0;
      event_kind_two_ff     <= 1'b0;
      wake_source_select_ff <= 2'b00;
    end else if (wr_em) begin
      channel_on_one_ff     <= wdata_i[`SM_EN1_BIT];
      event_kind_one_ff     <= wdata_i[`SM_MOD1_BIT];
      channel_on_two_ff     <= wdata_i[`SM_EN2_BIT];
      event_kind_two_ff     <= wdata_i[`SM_MOD2_BIT];
      wake_source_select_ff <= wdata_i[`SM_WAKE_LO+1:`SM_WAKE_LO]; // RULE17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests, level selects and wake
  assign threshold_select_one_o = lvl_one_ff; // RULE10
  assign threshold_select_two_o = lvl_two_ff; // RULE11

  // Combinational so enabling while low requests at once
  assign irq_one_o     = act_one & low_one & ~event_kind_one_ff; // RULE1 RULE2 RULE21
  assign rst_req_one_o = channel_on_one_ff & low_one & event_kind_one_ff; // RULE2 RULE23
  assign irq_two_o     = act_two & low_two & ~event_kind_two_ff; // RULE1 RULE3 RULE21
  assign rst_req_two_o = channel_on_two_ff & low_two & event_kind_two_ff; // RULE3 RULE23

  // Supply recovered on every enabled channel, with at least one channel enabled
  always @* begin
    wake_ok = (channel_on_one_ff | channel_on_two_ff) &
              ~(channel_on_one_ff & low_one) & ~(channel_on_two_ff & low_two);
  end

  assign wake_o = (wake_source_select_ff == `SM_WAKE_PIN)    ? stop_pin_i : // RULE18
                  (wake_source_select_ff == `SM_WAKE_SUPPLY) ? wake_ok : // RULE18
                  (wake_source_select_ff == `SM_WAKE_EITHER) ? (stop_pin_i | wake_ok) :
                  1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  assign nxt_rdata =
    (addr_i == `SM_OFF_FLAGS_LEVELS) ?
      {sticky_two_ff, live_two_ff, lvl_two_ff, sticky_one_ff, live_one_ff, lvl_one_ff} :
    (addr_i == `SM_OFF_ENABLE_MODE) ?
      {2'b00, wake_source_select_ff, event_kind_two_ff, channel_on_two_ff, // RULE16
       event_kind_one_ff, channel_on_one_ff} :
    8'h00;

  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? nxt_rdata : 8'h00;
    end
  end

endmodule // supply_monitor_ctrl
`default_nettype wire

// >>> supply_monitor_checker_assertions.sv
/* Checker of register port and request outputs.
   Assumes only the top module's ports are seen. */
`default_nettype none
module supply_monitor_checker (
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        below_one_i,
  input wire logic        below_two_i,
  input wire logic [1:0]  threshold_select_one_o,
  input wire logic [1:0]  threshold_select_two_o,
  input wire logic        irq_one_o,
  input wire logic        irq_two_o,
  input wire logic        rst_req_one_o,
  input wire logic        rst_req_two_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_wr_lvl;
    wr_i && addr_i == 12'h0fc6;
  endsequence
  sequence s_rd_ctl;
    rd_i && addr_i == 12'h0fc7;
  endsequence
  a_lvl_one: assert property (s_wr_lvl |=> threshold_select_one_o == $past(wdata_i[1:0]))
    else $error("level one select wrong");
  a_lvl_two: assert property (s_wr_lvl |=> threshold_select_two_o == $past(wdata_i[5:4]))
    else $error("level two select wrong");
  a_rst_one: assert property (rst_req_one_o |-> $past(below_one_i, 2))
    else $error("reset one without low supply");
  a_rst_two: assert property (rst_req_two_o |-> $past(below_two_i, 2))
    else $error("reset two without low supply");
  a_kind_one: assert property (!(irq_one_o && rst_req_one_o))
    else $error("channel one raised both requests");
  a_kind_two: assert property (!(irq_two_o && rst_req_two_o))
    else $error("channel two raised both requests");
  a_rst_hold: assert property (rst_req_one_o && $past(below_one_i) && !wr_i |=> rst_req_one_o)
    else $error("reset one dropped while low");
  a_ctl_top: assert property (s_rd_ctl |=> rdata_o[7:6] == 2'b00)
    else $error("control top bits not zero");
endmodule // supply_monitor_checker
bind supply_monitor_ctrl supply_monitor_checker supply_monitor_checker_i (.mclk_i, .reset_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .below_one_i, .below_two_i, .threshold_select_one_o,
  .threshold_select_two_o, .irq_one_o, .irq_two_o, .rst_req_one_o, .rst_req_two_o);
`default_nettype wire

// >>> supply_comparator_model.sv
/* Comparator model: supply in millivolts against the selected levels.
   Assumes the bench sets the supply just after a clock edge. */
`default_nettype none
module supply_comparator_model (
  input  wire logic [1:0]  sel_one_i,
  input  wire logic [1:0]  sel_two_i,
  input  wire logic [15:0] supply_mv_i,
  output wire logic        below_one_o,
  output wire logic        below_two_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] lvl_one [4] = '{16'h1194, 16'h1068, 16'h0e74, 16'h0c4e};
  localparam logic [15:0] lvl_two [4] = '{16'h092e, 16'h0c4e, 16'h0b22, 16'h0a5a};
  assign below_one_o = supply_mv_i < lvl_one[sel_one_i];
  assign below_two_o = supply_mv_i < lvl_two[sel_two_i];
endmodule // supply_comparator_model
`default_nettype wire

// >>> tb.sv
/* Bench of the supply monitor control.
   Assumes the model and checker files compiled first. */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic run_mode_i = 1'b1, stop_pin_i = 1'b0;
  logic [11:0] addr_i = 12'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic [15:0] supply = 16'h1388;
  wire logic [7:0] rdata_o;
  wire logic [1:0] sel1, sel2;
  wire logic below1, below2, irq1, irq2, rst1, rst2, wake;
  int errors = 0, checks_done = 0;
  logic [31:0] rows [9] = '{32'h0013_8800, 32'h000f_a00c, 32'h9a0f_a01a, 32'hbb0b_b83f,
    32'ha909_c4ed, 32'h0009_c48c, 32'h0013_8808, 32'h0013_8800, 32'hcc13_8800};
  supply_monitor_ctrl supply_monitor_ctrl_i (.mclk_i, .reset_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .below_one_i(below1), .below_two_i(below2), .threshold_select_one_o(sel1),
    .threshold_select_two_o(sel2), .run_mode_i, .stop_pin_i, .irq_one_o(irq1),
    .irq_two_o(irq2), .rst_req_one_o(rst1), .rst_req_two_o(rst2), .wake_o(wake));
  supply_comparator_model supply_comparator_model_i (.sel_one_i(sel1), .sel_two_i(sel2),
    .supply_mv_i(supply), .below_one_o(below1), .below_two_o(below2));
  initial forever #50 mclk_i = ~mclk_i;
  task automatic cyc(int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    cyc(1);
    wr_i <= 1'b0;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(logic [11:0] a, logic [7:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    cyc(1);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(rdata_o, exp);
    cyc(1);
  endtask
  task automatic end_sim;
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    cyc(6);
    reset_i <= 1'b0;
    cyc(1);
    rc(12'h0fc6, 8'h00);
    wr(12'h0fc7, 8'hc5);
    rc(12'h0fc7, 8'h05);
    foreach (rows[i]) begin
      wr(12'h0fc6, rows[i][31:24]);
      cyc(4);
      supply <= rows[i][23:8];
      cyc(5);
      rc(12'h0fc6, rows[i][7:0]);
    end
    supply <= 16'h07d0;
    cyc(4);
    chk({irq1, irq2, rst1, rst2}, 8'h0c);
    run_mode_i <= 1'b0;
    cyc(4);
    chk(irq1, 8'h00);
    run_mode_i <= 1'b1;
    wr(12'h0fc7, 8'h0a);
    cyc(4);
    chk({irq1, irq2, rst1, rst2}, 8'h00);
    wr(12'h0fc7, 8'h0f);
    cyc(4);
    chk({irq1, irq2, rst1, rst2}, 8'h03);
    supply <= 16'h1388;
    for (int c = 0; c < 8; c++) begin
      wr(12'h0fc7, {2'b00, c[2:1], 4'b0101});
      stop_pin_i <= c[0];
      cyc(4);
      chk(wake, c[2:1] == 2'b00 ? c[0] : c[2:1] != 2'b11);
    end
    reset_i <= 1'b1;
    cyc(2);
    reset_i <= 1'b0;
    cyc(1);
    rc(12'h0fc7, 8'h00);
    end_sim();
  end
  initial begin
    cyc(3000);
    errors++;
    end_sim();
  end
endmodule // tb
`default_nettype wire
